// ---- src/eil_pkg.sv ----
/*
  Package for the external interrupt latch: register map, field layout,
  bus answer codes and the carrier structs.
  Assumes a 32-bit Avalon-MM register bus with word addresses in bytes.
*/
package eil_pkg;

  localparam int unsigned ADDR_W = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CONFIG         = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS     = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK       = 4'hC;

  // Status/control register fields
  localparam int unsigned BIT_MODE    = 0;
  localparam int unsigned BIT_MASK    = 1;
  localparam int unsigned BIT_ACK     = 2;
  localparam int unsigned BIT_PENDING = 3;
  localparam int unsigned BIT_PIN_LVL = 4;

  // Config register fields
  localparam int unsigned BIT_PIN_EN  = 0;

  // Event status bits
  localparam int unsigned EVT_W        = 2;
  localparam int unsigned EVT_LATCHED  = 0;
  localparam int unsigned EVT_FALL     = 1;

  localparam logic       MODE_RST     = 1'h0;
  localparam logic       MASK_RST     = 1'h0;
  localparam logic       PIN_EN_RST   = 1'h0;
  localparam logic [1:0] RESP_OK      = 2'h0;
  localparam logic [1:0] RESP_DECERR  = 2'h3;
  localparam logic [31:0] RD_ZERO     = 32'h0;

  typedef enum logic [0:0] {
    EIL_IDLE = 1'b0,
    EIL_RESP = 1'b1
  } eil_bus_e;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } eil_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  response;
  } eil_rsp_s;

  typedef struct packed {
    eil_bus_e             bus;
    logic [31:0]          rdata;
    logic [1:0]           resp;
    logic [1:0]           pin_sync;
    logic                 pin_prev;
    logic                 req_latch;
    logic                 mode;
    logic                 mask;
    logic                 pin_en;
    logic [EVT_W-1:0]     evt_status;
    logic [EVT_W-1:0]     evt_mask;
  } eil_state_s;

endpackage : eil_pkg

// ---- src/eil_top.sv ----
/*
  External interrupt latch: one active-low interrupt pin latched into a
  request, cleared by vector fetch, software acknowledge or reset.
  Assumes the pin and the break-clear-allow strap come from outside the
  clock domain; vector fetch and break state come from mclk_i logic.
*/
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
// Function
// - Latch only while pin function enabled
// - Qualifying transitions set a sticky request latch
// - Vector fetch clears the request latch
// - Acknowledge write clears latch, reads zero
// - Reset clears latch and mode bit
// - Reset to edge mode, software selects mode
// - Level mode: request held while pin low
// - Level mode: drop after high plus ack
// - Edge mode: acknowledge clears latch immediately
// - Edge after acknowledge sets latch again
// - Mask blocks forwarding, latch stays
// - Pending flag readable, mask independent
// - Mask and mode are read/write bits
// - Latch in standby, unmasked request wakes
// - Pin level readable for branch tests
module eil_top
  import eil_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  input  wire logic              irq_pin_n_i,
  input  wire logic              vector_fetch_i,
  input  wire logic              break_state_i,
  input  wire logic              break_clear_allow_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic      [1:0]        avs_response_o,
  output logic                   cpu_irq_req_o,
  output logic                   wakeup_o,
  output logic                   pin_level_o,
  output logic                   irq_o
);

  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [1:0] bca_sync_q;
  eil_req_s   req;
  eil_rsp_s   rsp;
  eil_state_s state_q;
  eil_state_s state_d;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFS_STATUS_CONTROL) || (a == OFS_CONFIG) ||
                (a == OFS_EVT_STATUS) || (a == OFS_EVT_MASK);
  endfunction : is_mapped

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Strap-like input, synchronised before use
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      bca_sync_q <= 2'h0;
    end else begin
      bca_sync_q <= {bca_sync_q[0], break_clear_allow_i};
    end
  end

  assign req.address    = avs_address_i;
  assign req.read       = avs_read_i;
  assign req.write      = avs_write_i;
  assign req.writedata  = avs_writedata_i;
  assign req.byteenable = avs_byteenable_i;

  always_comb begin
    logic pin_lvl;
    logic fall;
    logic low_lvl;
    logic take;
    logic wr;
    logic clr_ok;
    logic sw_ack;
    logic ack;
    logic set_evt;
    logic [EVT_W-1:0] evt_set;
    logic [7:0] sc_rd;
    pin_lvl = 1'b0;
    fall    = 1'b0;
    low_lvl = 1'b0;
    take    = 1'b0;
    wr      = 1'b0;
    clr_ok  = 1'b0;
    sw_ack  = 1'b0;
    ack     = 1'b0;
    set_evt = 1'b0;
    evt_set = '0;
    sc_rd   = 8'h00;
    state_d = state_q;

    state_d.pin_sync = {state_q.pin_sync[0], irq_pin_n_i};
    pin_lvl = state_q.pin_sync[1];
    state_d.pin_prev = pin_lvl;
    // Edge seen only on the second stage, never the metastable first
    fall    = state_q.pin_en && state_q.pin_prev && !pin_lvl;
    low_lvl = state_q.pin_en && state_q.mode && !pin_lvl;

    take   = (state_q.bus == EIL_IDLE) && (req.read || req.write);
    wr     = take && req.write && req.byteenable[0];
    clr_ok = !break_state_i || bca_sync_q[1];
    sw_ack = wr && (req.address == OFS_STATUS_CONTROL) &&
             req.writedata[BIT_ACK];
    ack    = (vector_fetch_i || sw_ack) && clr_ok;

    // Level mode keeps the latch re-set while low, so an ack only sticks
    // once the pin is high; an ack given while the pin is low is lost.
    if (ack) begin
      state_d.req_latch = 1'b0;
    end
    if (fall || low_lvl) begin
      state_d.req_latch = 1'b1;
    end

    evt_set = '0;
    evt_set[EVT_LATCHED] = (fall || low_lvl) && !state_q.req_latch;
    evt_set[EVT_FALL]    = fall;

    if (wr) begin
      case (req.address)
        OFS_STATUS_CONTROL: begin
          state_d.mode = req.writedata[BIT_MODE];
          state_d.mask = req.writedata[BIT_MASK];
        end
        OFS_CONFIG: begin
          state_d.pin_en = req.writedata[BIT_PIN_EN];
        end
        OFS_EVT_STATUS: begin
          if (clr_ok) begin
            state_d.evt_status = state_q.evt_status &
                                 ~req.writedata[EVT_W-1:0];
          end
        end
        OFS_EVT_MASK: begin
          state_d.evt_mask = req.writedata[EVT_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Set wins over a same-cycle clear
    state_d.evt_status = state_d.evt_status | evt_set;

    sc_rd = 8'h00;
    sc_rd[BIT_MODE]    = state_q.mode;
    sc_rd[BIT_MASK]    = state_q.mask;
    sc_rd[BIT_ACK]     = 1'b0;
    sc_rd[BIT_PENDING] = state_q.req_latch;
    sc_rd[BIT_PIN_LVL] = pin_lvl;

    case (state_q.bus)
      EIL_IDLE: begin
        if (take) begin
          state_d.bus   = EIL_RESP;
          state_d.resp  = is_mapped(req.address) ? RESP_OK : RESP_DECERR;
          state_d.rdata = RD_ZERO;
          if (req.read) begin
            case (req.address)
              OFS_STATUS_CONTROL: state_d.rdata = {24'h0, sc_rd};
              OFS_CONFIG: state_d.rdata = {31'h0, state_q.pin_en};
              OFS_EVT_STATUS: state_d.rdata = {30'h0, state_q.evt_status};
              OFS_EVT_MASK: state_d.rdata = {30'h0, state_q.evt_mask};
              default: state_d.rdata = RD_ZERO;
            endcase
          end
        end
      end
      EIL_RESP: begin
        state_d.bus = EIL_IDLE;
      end
      default: begin
        state_d.bus = EIL_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q.bus        <= EIL_IDLE;
      state_q.rdata      <= RD_ZERO;
      state_q.resp       <= RESP_OK;
      state_q.pin_sync   <= 2'h3;
      state_q.pin_prev   <= 1'b1;
      state_q.req_latch  <= 1'b0;
      state_q.mode       <= MODE_RST;
      state_q.mask       <= MASK_RST;
      state_q.pin_en     <= PIN_EN_RST;
      state_q.evt_status <= '0;
      state_q.evt_mask   <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Waitrequest low only in the answer cycle: one wait state per access
  assign rsp.waitrequest = !(state_q.bus == EIL_RESP);
  assign rsp.readdata    = state_q.rdata;
  assign rsp.response    = state_q.resp;

  assign avs_readdata_o    = rsp.readdata;
  assign avs_waitrequest_o = rsp.waitrequest;
  assign avs_response_o    = rsp.response;
  assign cpu_irq_req_o     = state_q.req_latch && !state_q.mask;
  assign wakeup_o          = state_q.req_latch && !state_q.mask;
  assign pin_level_o       = state_q.pin_sync[1];
  assign irq_o             = |(state_q.evt_status & state_q.evt_mask);

endmodule : eil_top

// ---- test/eil_asserts.sv ----
/* Port checker for the interrupt latch.
   Assumes it is bound into eil_top and sees only its ports. */
`timescale 1ns/100ps
module eil_asserts
  import eil_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              reset_n_i,
  input wire logic              irq_pin_n_i,
  input wire logic              break_state_i,
  input wire logic              break_clear_allow_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic              avs_read_i,
  input wire logic              avs_write_i,
  input wire logic [31:0]       avs_writedata_i,
  input wire logic [3:0]        avs_byteenable_i,
  input wire logic [31:0]       avs_readdata_o,
  input wire logic              avs_waitrequest_o,
  input wire logic              cpu_irq_req_o,
  input wire logic              wakeup_o,
  input wire logic              pin_level_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic sc_done;
  assign sc_done = !avs_waitrequest_o && avs_address_i == OFS_STATUS_CONTROL;
  chk_wake_follows: assert property (wakeup_o == cpu_irq_req_o)
    else $error("wakeup differs from request");
  chk_pin_level: assert property ($stable(irq_pin_n_i) [*8] |->
    pin_level_o == irq_pin_n_i) else $error("pin level wrong");
  chk_ack_reads0: assert property (sc_done && avs_read_i |->
    !avs_readdata_o[BIT_ACK] && avs_readdata_o[31:5] == 27'h0)
    else $error("ack or spare bits read back");
  chk_mask_blocks: assert property (sc_done && avs_write_i &&
    avs_byteenable_i[0] && avs_writedata_i[BIT_MASK] |=> !cpu_irq_req_o)
    else $error("masked request forwarded");
  chk_pending_seen: assert property (sc_done && avs_read_i &&
    $past(cpu_irq_req_o) && cpu_irq_req_o |-> avs_readdata_o[BIT_PENDING])
    else $error("pending flag missing");
  chk_reset_clears: assert property ($rose(reset_n_i) |->
    !cpu_irq_req_o ##1 !cpu_irq_req_o) else $error("request after reset");
  chk_wait_one: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("answer timing wrong");
  // Allow is resynchronised inside, so demand three low samples first
  chk_break_hold: assert property (break_state_i &&
    !break_clear_allow_i && !$past(break_clear_allow_i) &&
    !$past(break_clear_allow_i, 2) && !avs_write_i && cpu_irq_req_o
    |=> cpu_irq_req_o) else $error("request cleared in break");
endmodule : eil_asserts

bind eil_top eil_asserts u_chk (.*);

// ---- test/eil_pin_model.sv ----
/* External device on the active-low interrupt pin.
   Assumes the bench asks for low periods of two cycles or more. */
`timescale 1ns/100ps
module eil_pin_model (
  input  wire logic mclk_i,
  input  wire logic hold_low_i,
  output logic      pin_n_o
);
  logic low_q = 1'b0;
  // Released pin goes to the pull-up level
  assign pin_n_o = !low_q;
  always_ff @(posedge mclk_i) low_q <= hold_low_i;
endmodule : eil_pin_model

// ---- test/external_irq_latch_bench.sv ----
/* Bench for the interrupt latch: bus master, pin model, break control.
   Assumes eil_top, eil_pin_model and the bound checker. */
`timescale 1ns/100ps
module external_irq_latch_bench;
  import eil_pkg::*;
  logic        mclk_i = 0, reset_n_i = 0, hold_low = 0, vector_fetch_i = 0;
  logic        break_state_i = 0, break_clear_allow_i = 0, irq_pin_n_i;
  logic        avs_read_i = 0, avs_write_i = 0;
  logic [3:0]  avs_address_i = 4'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
  logic        avs_waitrequest_o, cpu_irq_req_o, wakeup_o, pin_level_o, irq_o;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [1:0]  avs_response_o;
  int          n_fail = 0, total_checks = 0;
  eil_pin_model u_pin (.mclk_i(mclk_i), .hold_low_i(hold_low),
    .pin_n_o(irq_pin_n_i));
  eil_top u_dut (.*);
  initial forever #12.5 mclk_i = !mclk_i;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge mclk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 40);
    rd = avs_readdata_o;
    avs_write_i <= 0;
    avs_read_i <= 0;
    if (k >= 40) begin
      n_fail++;
      tally_and_finish();
    end
    @(posedge mclk_i);
  endtask : bus
  task automatic pulse(input int n);
    hold_low <= 1;
    repeat (n) @(posedge mclk_i);
    hold_low <= 0;
    repeat (7) @(posedge mclk_i);
  endtask : pulse
  task automatic vf();
    vector_fetch_i <= 1;
    @(posedge mclk_i);
    vector_fetch_i <= 0;
    repeat (2) @(posedge mclk_i);
  endtask : vf
  function automatic logic [31:0] sc(logic md, logic mk, logic pd, logic lv);
    return {27'h0, lv, pd, 1'b0, mk, md};
  endfunction : sc
  initial begin
    void'($urandom(95));
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1;
    repeat (4) @(posedge mclk_i);
    bus(0, OFS_STATUS_CONTROL, 0);
    chk(rd, sc(0, 0, 0, 1));
    bus(0, 4'h2, 0);
    chk(rd, 0);
    chk(avs_response_o, RESP_DECERR);
    pulse(3);
    chk(cpu_irq_req_o, 0);
    bus(1, OFS_CONFIG, 32'h1);
    bus(1, OFS_EVT_MASK, 32'h1);
    // A write without the low byte lane must leave mode and mask alone
    avs_byteenable_i <= 4'h0;
    bus(1, OFS_STATUS_CONTROL, 32'h3);
    avs_byteenable_i <= 4'hF;
    bus(0, OFS_STATUS_CONTROL, 0);
    chk(rd, sc(0, 0, 0, 1));
    chk(avs_response_o, RESP_OK);
    $display("reset and enable done");
    for (int i = 0; i < 6; i++) begin
      pulse(2 + $urandom % 4);
      chk({cpu_irq_req_o, wakeup_o, irq_o}, 3'h7);
      bus(0, OFS_STATUS_CONTROL, 0);
      chk(rd, sc(0, 0, 1, 1));
      bus(0, OFS_EVT_STATUS, 0);
      chk(rd, 32'h3);
      if (i % 2) vf();
      else bus(1, OFS_STATUS_CONTROL, 32'h4);
      chk(cpu_irq_req_o, 0);
      bus(1, OFS_EVT_STATUS, 32'h3);
      chk(irq_o, 0);
    end
    $display("edge mode done");
    pulse(2);
    bus(1, OFS_STATUS_CONTROL, 32'h2);
    bus(0, OFS_STATUS_CONTROL, 0);
    chk(rd, sc(0, 1, 1, 1));
    bus(1, OFS_STATUS_CONTROL, 32'h0);
    chk(cpu_irq_req_o, 1);
    bus(1, OFS_STATUS_CONTROL, 32'h5);
    hold_low <= 1;
    repeat (6) @(posedge mclk_i);
    bus(1, OFS_STATUS_CONTROL, 32'h5);
    bus(0, OFS_STATUS_CONTROL, 0);
    chk(rd, sc(1, 0, 1, 0));
    hold_low <= 0;
    repeat (6) @(posedge mclk_i);
    chk(cpu_irq_req_o, 1);
    bus(1, OFS_STATUS_CONTROL, 32'h4);
    chk(cpu_irq_req_o, 0);
    $display("mask and level done");
    break_state_i <= 1;
    pulse(3);
    bus(1, OFS_STATUS_CONTROL, 32'h4);
    vf();
    chk(cpu_irq_req_o, 1);
    break_clear_allow_i <= 1;
    repeat (4) @(posedge mclk_i);
    bus(1, OFS_STATUS_CONTROL, 32'h4);
    chk(cpu_irq_req_o, 0);
    break_state_i <= 0;
    break_clear_allow_i <= 0;
    bus(1, OFS_STATUS_CONTROL, 32'h1);
    hold_low <= 1;
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1;
    repeat (4) @(posedge mclk_i);
    bus(0, OFS_STATUS_CONTROL, 0);
    chk(rd, sc(0, 0, 0, 0));
    hold_low <= 0;
    $display("break and reset done");
    tally_and_finish();
  end
endmodule : external_irq_latch_bench
